// ==== verilog/sbha_pkg.sv ====
// Shared constants for the serial bus host access engine
package sbha_pkg;

  // Configuration-space byte offsets
  localparam logic [7:0] SBHA_OFF_DATA   = 8'hb0;
  localparam logic [7:0] SBHA_OFF_WORD   = 8'hb1;
  localparam logic [7:0] SBHA_OFF_TARGET = 8'hb2;
  localparam logic [7:0] SBHA_OFF_CTRL   = 8'hb3;

  // Reset values
  localparam logic [7:0] SBHA_RST_DATA   = 8'h00;
  localparam logic [7:0] SBHA_RST_WORD   = 8'h00;
  localparam logic [7:0] SBHA_RST_TARGET = 8'h00;
  localparam logic       SBHA_RST_BIT    = 1'b0;

  // Field positions
  localparam int SBHA_TGT_DIR_BIT  = 0;  // Direction, 1 = read
  localparam int SBHA_TGT_ADDR_LSB = 1;  // Target address bits 7:1
  localparam int SBHA_CTRL_MODE    = 7;  // Address mode select
  localparam int SBHA_CTRL_BUSY    = 5;  // Request busy flag
  localparam int SBHA_CTRL_FAST    = 2;  // Fast clock for test
  localparam int SBHA_CTRL_ERR     = 1;  // Bus error flag

  // Timing: figures in ns, counts derived from the system clock
  localparam int SBHA_CLK_PERIOD_NS  = 40;
  localparam int SBHA_SCL_PERIOD_NS  = 16667;
  localparam int SBHA_FAST_PERIOD_NS = 250;
  // Quarter bit periods, rounded down so the bus is never slower
  localparam int SBHA_QTR_CYC =
    SBHA_SCL_PERIOD_NS / (4 * SBHA_CLK_PERIOD_NS);
  localparam int SBHA_FAST_RAW =
    SBHA_FAST_PERIOD_NS / (4 * SBHA_CLK_PERIOD_NS);
  localparam int SBHA_FAST_QTR_CYC = (SBHA_FAST_RAW < 1) ? 1 : SBHA_FAST_RAW;

  // Bit-level engine states
  typedef enum logic [2:0] {
    SBHA_ST_IDLE  = 3'b000,
    SBHA_ST_START = 3'b001,
    SBHA_ST_TX    = 3'b010,
    SBHA_ST_RX    = 3'b011,
    SBHA_ST_ACK   = 3'b100,
    SBHA_ST_STOP  = 3'b101
  } sbha_state_type;

  // Which byte of the frame is in flight
  typedef enum logic [1:0] {
    SBHA_STEP_ADDR  = 2'b00,
    SBHA_STEP_WORD  = 2'b01,
    SBHA_STEP_RADDR = 2'b10,
    SBHA_STEP_DATA  = 2'b11
  } sbha_step_type;

endpackage : sbha_pkg

// ==== verilog/sbha_tick.sv ====
// Quarter-bit tick divider for the serial clock
module sbha_tick
  import sbha_pkg::*;
#(
  parameter int NORM_CYC = SBHA_QTR_CYC,      // Normal quarter period
  parameter int FAST_CYC = SBHA_FAST_QTR_CYC  // Test quarter period
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic ce_i,
  input  wire logic run_i,    // Count only while a frame runs
  input  wire logic fast_i,   // Select the test rate
  output logic      tick_o    // One-cycle pulse per quarter bit
);

  // Refuse counts the 12-bit counter cannot hold
  initial begin
    if (NORM_CYC < 1 || NORM_CYC > 4095 || FAST_CYC < 1 || FAST_CYC > 4095)
      $error("sbha_tick: quarter period out of range");
  end

  localparam logic [11:0] NORM_LAST = 12'(NORM_CYC - 1);
  localparam logic [11:0] FAST_LAST = 12'(FAST_CYC - 1);

  logic [11:0] cnt_q, cnt_d;   // Cycles within the quarter
  logic [11:0] last;           // Terminal count for the rate

  // Next count; restarts whenever the engine is idle
  always_comb begin
    last   = fast_i ? FAST_LAST : NORM_LAST;
    tick_o = run_i && (cnt_q >= last);
    if (!run_i || tick_o) begin
      cnt_d = 12'h000;
    end else begin
      cnt_d = cnt_q + 12'h001;
    end
  end

  // Counter register, frozen while the clock enable is low
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cnt_q <= 12'h000;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
    end
  end

endmodule : sbha_tick

// ==== verilog/sbha_top.sv ====
// Software-launched single-byte two-wire bus access engine
// What this block does
// - Read byte lands in data register in the same cycle busy clears
// - Data and word registers reset on every reset
// - Word address selects byte inside target
// - Writing target register while idle starts one transfer
// - Target register bits 7:1 hold address, reset zero
// - Target bit 0 selects write zero, read one
// - Busy flag stays set while transfer runs
// - Failed transfer sets error flag, software clears
// - Address mode one omits the word address
module sbha_top
  import sbha_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,              // Power-on reset
  input  wire logic       ce_i,                 // Freezes all state
  input  wire logic       link_reset_pin_b_i,   // Link reset pin
  input  wire logic       global_reset_pin_b_i, // Global reset pin
  input  wire logic [7:0] cfg_addr_i,           // Config byte offset
  input  wire logic       cfg_wr_i,             // Config write strobe
  input  wire logic       cfg_rd_i,             // Config read strobe
  input  wire logic [7:0] cfg_wdata_i,          // Config write data
  output logic      [7:0] cfg_rdata_o,          // Config read data
  input  wire logic       scl_i,                // Clock pin level
  output logic            scl_o,                // Clock pin drive value
  output logic            scl_oe_o,             // Clock pin pulled low
  input  wire logic       sda_i,                // Data pin level
  output logic            sda_o,                // Data pin drive value
  output logic            sda_oe_o              // Data pin pulled low
);

  // Two-flop synchronisers for pins from outside the clock domain
  logic [1:0] lrst_s_q, global_reset_pin_s_q, scl_s_q, sda_s_q;
  logic       rst_int_b;   // Combined internal reset, active low

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      lrst_s_q <= 2'b00;
      global_reset_pin_s_q <= 2'b00;
      scl_s_q  <= 2'b11;
      sda_s_q  <= 2'b11;
    end else if (ce_i) begin
      lrst_s_q <= {lrst_s_q[0], link_reset_pin_b_i};
      global_reset_pin_s_q <= {global_reset_pin_s_q[0], global_reset_pin_b_i};
      scl_s_q  <= {scl_s_q[0], scl_i};
      sda_s_q  <= {sda_s_q[0], sda_i};
    end
  end

  // Any of the three resets clears the register file and engine
  assign rst_int_b = rst_b_i && lrst_s_q[1] && global_reset_pin_s_q[1];

  // Software-visible registers
  logic [7:0] data_q, data_d;       // Data byte
  logic [7:0] word_q, word_d;       // Word address
  logic [7:0] tgt_q, tgt_d;         // Target address and direction
  logic       mode_q, mode_d;       // Address mode select
  logic       fast_q, fast_d;       // Test clock rate
  logic       err_q, err_d;         // Bus error flag
  logic [7:0] rdata_q, rdata_d;     // Registered read data

  // Engine state
  sbha_state_type st_q, st_d;
  sbha_step_type  step_q, step_d;
  logic [1:0]     ph_q, ph_d;       // Quarter within the bit
  logic [2:0]     bit_q, bit_d;     // Bit within the byte
  logic [7:0]     sh_q, sh_d;       // Shift register
  logic           scl_lo_q, scl_lo_d;
  logic           sda_lo_q, sda_lo_d;
  logic           nack_q, nack_d;   // Acknowledge missing
  logic           fail_q, fail_d;   // Frame ended in error

  logic           busy;             // Request busy flag
  logic           tick;             // Quarter-bit pulse
  logic           adv;              // Tick not held by stretching
  logic           launch;           // Software start request
  logic           is_read;          // Direction of the request
  logic           done;             // Stop finished

  assign busy    = (st_q != SBHA_ST_IDLE);
  assign is_read = tgt_q[SBHA_TGT_DIR_BIT];
  assign launch  = cfg_wr_i && (cfg_addr_i == SBHA_OFF_TARGET)
                   && !busy;

  // Quarter tick source; counts only while a frame runs
  sbha_tick #(
    .NORM_CYC (SBHA_QTR_CYC),
    .FAST_CYC (SBHA_FAST_QTR_CYC)
  ) u_tick (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_int_b),
    .ce_i      (ce_i),
    .run_i     (busy),
    .fast_i    (fast_q),
    .tick_o    (tick)
  );

  // Sample quarter waits for the released clock to read high
  assign adv  = tick && !(ph_q == 2'd2 && !scl_lo_q && !scl_s_q[1]);
  assign done = adv && (st_q == SBHA_ST_STOP) && (ph_q == 2'd3);

  // Frame sequencer: start, bytes, acks, stop
  always_comb begin
    st_d     = st_q;
    step_d   = step_q;
    ph_d     = ph_q;
    bit_d    = bit_q;
    sh_d     = sh_q;
    scl_lo_d = scl_lo_q;
    sda_lo_d = sda_lo_q;
    nack_d   = nack_q;
    fail_d   = fail_q;
    if (st_q == SBHA_ST_IDLE) begin
      // Idle bus: both lines released
      scl_lo_d = 1'b0;
      sda_lo_d = 1'b0;
      if (launch) begin
        st_d   = SBHA_ST_START;
        step_d = SBHA_STEP_ADDR;
        ph_d   = 2'd0;
        fail_d = 1'b0;
      end
    end else if (adv) begin
      ph_d = ph_q + 2'd1;
      case (st_q)
        SBHA_ST_START: begin
          // Release both, then pull data low while clock high
          case (ph_q)
            2'd0:    begin sda_lo_d = 1'b0; scl_lo_d = 1'b0; end
            2'd2:    sda_lo_d = 1'b1;
            2'd3:    begin
              scl_lo_d = 1'b1;
              st_d     = SBHA_ST_TX;
              bit_d    = 3'd0;
              // Word mode sends a write address first, then reads
              // after a repeated start
              if (step_q == SBHA_STEP_RADDR) begin
                sh_d = {tgt_q[7:SBHA_TGT_ADDR_LSB], 1'b1};
              end else if (mode_q) begin
                sh_d = tgt_q;
              end else begin
                sh_d = {tgt_q[7:SBHA_TGT_ADDR_LSB], 1'b0};
              end
            end
            default: ;
          endcase
        end
        SBHA_ST_TX, SBHA_ST_RX: begin
          case (ph_q)
            2'd0: begin
              scl_lo_d = 1'b1;
              // Receiving leaves data released for the target
              sda_lo_d = (st_q == SBHA_ST_TX) ? !sh_q[7] : 1'b0;
            end
            2'd1: scl_lo_d = 1'b0;
            2'd2: sh_d = {sh_q[6:0], sda_s_q[1]};
            default: begin
              scl_lo_d = 1'b1;
              bit_d    = bit_q + 3'd1;
              if (bit_q == 3'd7) begin
                st_d = SBHA_ST_ACK;
              end
            end
          endcase
        end
        SBHA_ST_ACK: begin
          case (ph_q)
            // Released data is a wait for ack, or the host's nack
            // that ends a read
            2'd0:    begin scl_lo_d = 1'b1; sda_lo_d = 1'b0; end
            2'd1:    scl_lo_d = 1'b0;
            2'd2:    nack_d = sda_s_q[1];
            default: begin
              scl_lo_d = 1'b1;
              bit_d    = 3'd0;
              if (nack_q && step_q != SBHA_STEP_DATA) begin
                fail_d = 1'b1;
                st_d   = SBHA_ST_STOP;
              end else if (step_q == SBHA_STEP_DATA) begin
                fail_d = nack_q && !is_read;
                st_d   = SBHA_ST_STOP;
              end else if (step_q == SBHA_STEP_ADDR && !mode_q) begin
                step_d = SBHA_STEP_WORD;
                st_d   = SBHA_ST_TX;
                sh_d   = word_q;
              end else if (step_q == SBHA_STEP_WORD && is_read) begin
                step_d = SBHA_STEP_RADDR;
                st_d   = SBHA_ST_START;
              end else begin
                step_d = SBHA_STEP_DATA;
                st_d   = is_read ? SBHA_ST_RX : SBHA_ST_TX;
                sh_d   = data_q;
              end
            end
          endcase
        end
        SBHA_ST_STOP: begin
          // Data low under low clock, raise clock, then data
          case (ph_q)
            2'd0:    begin scl_lo_d = 1'b1; sda_lo_d = 1'b1; end
            2'd1:    scl_lo_d = 1'b0;
            2'd2:    sda_lo_d = 1'b0;
            default: st_d = SBHA_ST_IDLE;
          endcase
        end
        default: st_d = SBHA_ST_IDLE;
      endcase
    end
  end

  // Engine registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_int_b) begin
      st_q     <= SBHA_ST_IDLE;
      step_q   <= SBHA_STEP_ADDR;
      ph_q     <= 2'd0;
      bit_q    <= 3'd0;
      sh_q     <= 8'h00;
      scl_lo_q <= 1'b0;
      sda_lo_q <= 1'b0;
      nack_q   <= 1'b0;
      fail_q   <= 1'b0;
    end else if (ce_i) begin
      st_q     <= st_d;
      step_q   <= step_d;
      ph_q     <= ph_d;
      bit_q    <= bit_d;
      sh_q     <= sh_d;
      scl_lo_q <= scl_lo_d;
      sda_lo_q <= sda_lo_d;
      nack_q   <= nack_d;
      fail_q   <= fail_d;
    end
  end

  // Register file: software writes, engine deposits, reads
  always_comb begin
    data_d  = data_q;
    word_d  = word_q;
    tgt_d   = tgt_q;
    mode_d  = mode_q;
    fast_d  = fast_q;
    err_d   = err_q;
    rdata_d = rdata_q;
    if (cfg_wr_i) begin
      case (cfg_addr_i)
        SBHA_OFF_DATA: data_d = cfg_wdata_i;
        SBHA_OFF_WORD: word_d = cfg_wdata_i;
        // Target writes while busy are dropped; data, word and control writes still land
        SBHA_OFF_TARGET: if (!busy) tgt_d = cfg_wdata_i;
        SBHA_OFF_CTRL: begin
          mode_d = cfg_wdata_i[SBHA_CTRL_MODE];
          fast_d = cfg_wdata_i[SBHA_CTRL_FAST];
          // Writing one clears the error flag
          if (cfg_wdata_i[SBHA_CTRL_ERR]) err_d = 1'b0;
        end
        default: ;
      endcase
    end
    // Engine events override a clear in the same cycle
    if (done) begin
      if (fail_q) begin
        err_d = 1'b1;
      end else if (is_read) begin
        data_d = sh_q;
      end
    end
    if (cfg_rd_i) begin
      case (cfg_addr_i)
        SBHA_OFF_DATA:   rdata_d = data_q;
        SBHA_OFF_WORD:   rdata_d = word_q;
        SBHA_OFF_TARGET: rdata_d = tgt_q;
        SBHA_OFF_CTRL:   rdata_d = {mode_q, 1'b0, busy, 2'b00,
                                    fast_q, err_q, 1'b0};
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  // Register file storage
  always_ff @(posedge clk_sys_i) begin
    if (!rst_int_b) begin
      data_q  <= SBHA_RST_DATA;
      word_q  <= SBHA_RST_WORD;
      tgt_q   <= SBHA_RST_TARGET;
      mode_q  <= SBHA_RST_BIT;
      fast_q  <= SBHA_RST_BIT;
      err_q   <= SBHA_RST_BIT;
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      data_q  <= data_d;
      word_q  <= word_d;
      tgt_q   <= tgt_d;
      mode_q  <= mode_d;
      fast_q  <= fast_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
    end
  end

  // Open-drain pins: drive low only, straight from flip-flops
  assign cfg_rdata_o = rdata_q;
  assign scl_o       = 1'b0;
  assign sda_o       = 1'b0;
  assign scl_oe_o    = scl_lo_q;
  assign sda_oe_o    = sda_lo_q;

endmodule : sbha_top

// ==== dv/sbha_checker.sv ====
// Port-level assertions for the serial bus host access engine
module sbha_checker
  import sbha_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic       ce_i,
  input  wire logic [7:0] cfg_addr_i,
  input  wire logic       cfg_wr_i,
  input  wire logic       cfg_rd_i,
  input  wire logic [7:0] cfg_wdata_i,
  input  wire logic [7:0] cfg_rdata_o,
  input  wire logic       scl_oe_o,
  input  wire logic       sda_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int   idle_q;  // Cycles with both pins released
  int   wr_q;    // Cycles since the last target-address write
  logic fast_q;  // Shadow of the fast test clock bit
  logic quiet;   // No frame can be running now
  logic wr_ce;   // Write taken this edge
  logic rd_ce;   // Read taken this edge
  assign wr_ce = ce_i && cfg_wr_i;
  assign rd_ce = ce_i && cfg_rd_i;
  // Busy is not a port, so a long silence on both pins stands in for it
  assign quiet = idle_q >= 300 && wr_q >= 500;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // Counters saturate so a long idle spell never wraps
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      idle_q <= 1000;
      wr_q   <= 1000;
      fast_q <= 1'b0;
    end else begin
      idle_q <= (scl_oe_o || sda_oe_o) ? 0 :
                (idle_q < 1000 ? idle_q + 1 : 1000);
      // Only a target-address write can launch a frame
      wr_q   <= (wr_ce && cfg_addr_i == SBHA_OFF_TARGET) ? 0 :
                (wr_q < 1000 ? wr_q + 1 : 1000);
      if (wr_ce && cfg_addr_i == SBHA_OFF_CTRL) begin
        fast_q <= cfg_wdata_i[SBHA_CTRL_FAST];
      end
    end
  end
  a_reset_quiet: assert property (
    $rose(rst_b_i) |-> !scl_oe_o && !sda_oe_o && cfg_rdata_o == 8'h00)
    else $error("outputs not quiet after reset");
  a_launch_starts: assert property (
    wr_ce && cfg_addr_i == SBHA_OFF_TARGET && quiet
    |-> ##[1:400] $rose(sda_oe_o))
    else $error("target write did not start a frame");
  a_busy_after_launch: assert property (
    (wr_ce && cfg_addr_i == SBHA_OFF_TARGET && quiet) ##2
    (rd_ce && cfg_addr_i == SBHA_OFF_CTRL) |=> cfg_rdata_o[SBHA_CTRL_BUSY])
    else $error("busy not set after launch");
  a_busy_clears: assert property (
    rd_ce && cfg_addr_i == SBHA_OFF_CTRL && quiet
    |=> !cfg_rdata_o[SBHA_CTRL_BUSY])
    else $error("busy set while bus idle");
  a_data_readback: assert property (
    (wr_ce && cfg_addr_i == SBHA_OFF_DATA && quiet) ##2
    (rd_ce && cfg_addr_i == SBHA_OFF_DATA)
    |=> cfg_rdata_o == $past(cfg_wdata_i, 3))
    else $error("data register lost a write");
  a_err_clears: assert property (
    (wr_ce && cfg_addr_i == SBHA_OFF_CTRL && cfg_wdata_i[1] && quiet) ##2
    (rd_ce && cfg_addr_i == SBHA_OFF_CTRL) |=> !cfg_rdata_o[SBHA_CTRL_ERR])
    else $error("error flag not cleared");
  a_start_clock: assert property (
    $rose(sda_oe_o) && !scl_oe_o |-> ##[1:120] scl_oe_o)
    else $error("start not followed by clock low");
  a_stop_release: assert property (
    $fell(sda_oe_o) && !scl_oe_o |=> !scl_oe_o)
    else $error("clock pulled after stop");
  a_clock_low_span: assert property (
    !fast_q && $rose(scl_oe_o) |=> scl_oe_o [*8])
    else $error("clock low phase too short");
endmodule : sbha_checker

bind sbha_top sbha_checker u_chk (.clk_sys_i, .rst_b_i, .ce_i, .cfg_addr_i,
  .cfg_wr_i, .cfg_rd_i, .cfg_wdata_i, .cfg_rdata_o, .scl_oe_o, .sda_oe_o);

// ==== dv/sbha_target.sv ====
// Behavioural two-wire byte memory target with refusal and stretching
module sbha_target #(
  parameter logic [6:0] DEV = 7'h50  // Bus address it answers to
) (
  input  wire logic scl_i,      // Clock line level
  input  wire logic sda_i,      // Data line level
  input  wire logic nack_i,     // Refuse the address byte
  input  wire logic stretch_i,  // Hold the clock low after each fall
  output logic      scl_oe_o,   // High while pulling the clock low
  output logic      sda_oe_o    // High while pulling the data low
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [256];  // Byte store
  logic [7:0] sh = 8'h00; // Incoming shift register
  logic [7:0] ptr = 8'h00;// Word pointer, kept between frames
  int st = 0;             // 0 idle 1 addr 2 word 3 wdata 4 rdata
  int bc = 0;             // Bit count; 8 marks the acknowledge slot
  initial scl_oe_o = 1'b0;
  initial sda_oe_o = 1'b0;
  // Start or repeated start opens the address phase
  always @(negedge sda_i) if (scl_i) begin
    st = 1;
    bc = 0;
  end
  // Stop ends the frame
  always @(posedge sda_i) if (scl_i) st = 0;
  // Sample on the rising clock; host nack ends a read
  always @(posedge scl_i) if (st != 0) begin
    if (bc < 8) begin
      sh = {sh[6:0], sda_i};
      bc++;
    end else begin
      bc = 0;
      if (st == 4 && sda_i) st = 0;
    end
  end
  // Drive only while the clock is low, so no false start or stop
  always @(negedge scl_i) begin
    sda_oe_o = 1'b0;
    if (st != 0 && bc == 8) begin
      case (st)
        1: begin
          sda_oe_o = sh[7:1] == DEV && !nack_i;
          st = !sda_oe_o ? 0 : (sh[0] ? 4 : 2);
        end
        2: begin
          ptr = sh;
          st = 3;
          sda_oe_o = 1'b1;
        end
        3: begin
          mem[ptr] = sh;
          sda_oe_o = 1'b1;
        end
        default: ;
      endcase
    end else if (st == 4) sda_oe_o = !mem[ptr][7 - bc];
    // A slow target stretches the low phase
    if (stretch_i) begin
      scl_oe_o = 1'b1;
      #300 scl_oe_o = 1'b0;
    end
  end
endmodule : sbha_target

// ==== dv/testbench.sv ====
// Self-checking bench for the serial bus host access engine
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import sbha_pkg::*;
  localparam logic [6:0] DEV = 7'h50;  // Bus address of the model
  logic clk_sys_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1;
  logic lnk_b = 1'b1, glb_b = 1'b1, wr = 1'b0, rd = 1'b0;
  logic nack = 1'b0, str = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r, w, d;
  logic scl_oe, sda_oe, m_scl_oe, m_sda_oe;
  logic [31:0] lf = 32'hc376;  // Random source, fixed start
  int error_cnt = 0, compares = 0;
  wire scl = ~(scl_oe | m_scl_oe);  // Pull-ups on both lines
  wire sda = ~(sda_oe | m_sda_oe);
  always #20 clk_sys_i = ~clk_sys_i;
  sbha_top uut (.clk_sys_i, .rst_b_i, .ce_i, .link_reset_pin_b_i(lnk_b),
    .global_reset_pin_b_i(glb_b), .cfg_addr_i(addr), .cfg_wr_i(wr),
    .cfg_rd_i(rd), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .scl_i(scl),
    .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe));
  sbha_target #(.DEV(DEV)) eep (.scl_i(scl), .sda_i(sda), .nack_i(nack),
    .stretch_i(str), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // One config access, then an idle cycle so strobes never re-assert at once
  task automatic bus(input logic [7:0] a, input logic [7:0] v, input logic we);
    addr = a;
    wdata = v;
    wr = we;
    rd = !we;
    @(posedge clk_sys_i);
    #1 wr = 1'b0;
    rd = 1'b0;
    r = rdata;
    @(posedge clk_sys_i);
    #1;
  endtask : bus
  // Poll busy under a bound; a hang ends the run
  task automatic wait_done();
    for (int i = 0; i < 20000; i++) begin
      bus(SBHA_OFF_CTRL, 8'h00, 1'b0);
      if (r[SBHA_CTRL_BUSY] === 1'b0) break;
    end
    `CHK("busy", 1'b0, r[SBHA_CTRL_BUSY])
    if (r[SBHA_CTRL_BUSY] !== 1'b0) end_of_test();
  endtask : wait_done
  task automatic xfer(input logic [7:0] wa, input logic [7:0] v,
                      input logic rw);
    bus(SBHA_OFF_WORD, wa, 1'b1);
    if (!rw) bus(SBHA_OFF_DATA, v, 1'b1);
    bus(SBHA_OFF_TARGET, {DEV, rw}, 1'b1);
    wait_done();
  endtask : xfer
  initial begin
    repeat (4) @(posedge clk_sys_i);
    #1 rst_b_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    // Reset values, plus one unmapped offset
    for (int a = 0; a < 5; a++) begin
      bus(8'hb0 + a[7:0], 8'h00, 1'b0);
      `CHK("reset value", 8'h00, r)
    end
    // Random read-back of the two plain byte registers
    for (int k = 0; k < 8; k++) begin
      lf = lfsr(lf);
      bus(SBHA_OFF_DATA + {7'h00, k[0]}, lf[7:0], 1'b1);
      bus(SBHA_OFF_DATA + {7'h00, k[0]}, 8'h00, 1'b0);
      `CHK("byte reg", lf[7:0], r)
    end
    // A write with the clock enable low must not land
    ce_i = 1'b0;
    bus(SBHA_OFF_WORD, ~lf[7:0], 1'b1);
    ce_i = 1'b1;
    bus(SBHA_OFF_WORD, 8'h00, 1'b0);
    `CHK("frozen write", lf[7:0], r)
    // One write at the normal bus rate
    lf = lfsr(lf);
    w = lf[7:0];
    d = lf[15:8];
    xfer(w, d, 1'b0);
    `CHK("stored byte", d, eep.mem[w])
    // Fast rate: random writes and reads, some with a stretching target
    bus(SBHA_OFF_CTRL, 8'h04, 1'b1);
    for (int k = 0; k < 6; k++) begin
      lf = lfsr(lf);
      w = lf[7:0];
      d = lf[15:8];
      str = lf[16] || k == 0;  // First pass always stretches
      xfer(w, d, 1'b0);
      bus(SBHA_OFF_DATA, 8'h00, 1'b1);
      xfer(w, 8'h00, 1'b1);
      bus(SBHA_OFF_DATA, 8'h00, 1'b0);
      `CHK("read byte", d, r)
      bus(SBHA_OFF_TARGET, 8'h00, 1'b0);
      `CHK("target reg", {DEV, 1'b1}, r)
    end
    // Short mode: a stray word address would move the pointer
    bus(SBHA_OFF_CTRL, 8'h84, 1'b1);
    xfer(~w, 8'h00, 1'b1);
    bus(SBHA_OFF_DATA, 8'h00, 1'b0);
    `CHK("short read", d, r)
    // Refused address: error set, read byte not stored, then cleared
    bus(SBHA_OFF_CTRL, 8'h04, 1'b1);
    bus(SBHA_OFF_DATA, 8'h3c, 1'b1);
    nack = 1'b1;
    xfer(w, 8'h00, 1'b1);
    repeat (600) @(posedge clk_sys_i);
    #1 bus(SBHA_OFF_CTRL, 8'h00, 1'b0);
    `CHK("error flag", 8'h06, r)
    bus(SBHA_OFF_DATA, 8'h00, 1'b0);
    `CHK("kept data", 8'h3c, r)
    bus(SBHA_OFF_CTRL, 8'h06, 1'b1);
    bus(SBHA_OFF_CTRL, 8'h00, 1'b0);
    `CHK("error clear", 8'h04, r)
    nack = 1'b0;
    // Link reset pin, then global reset pin, clear the data register
    for (int k = 0; k < 2; k++) begin
      bus(SBHA_OFF_DATA, 8'ha5, 1'b1);
      lnk_b = k[0];
      glb_b = !k[0];
      repeat (3) @(posedge clk_sys_i);
      #1 lnk_b = 1'b1;
      glb_b = 1'b1;
      repeat (3) @(posedge clk_sys_i);
      #1 bus(SBHA_OFF_DATA, 8'h00, 1'b0);
      `CHK("pin reset", 8'h00, r)
    end
    end_of_test();
  end
endmodule : testbench
